/* File: async_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1 - full duplex, 8-bit frame mode and 9-bit frame mode
// RL2 - receiver shifts next byte while previous waits in buffer
// RL3 - one data window: read gives rx buffer, write loads tx
// RL4 - interrupt when tx-done or rx-done sets, if enabled
// RL5 - done flags cleared only by software writes
// RL6 - 9-bit frame: start, 8 data lsb first, ninth bit, stop
// RL7 - sent ninth bit equals tx_ninth_bit control field
// RL8 - received ninth bit to rx_ninth_bit; stop bit ignored
// RL9 - transmission starts when software writes the data window
// RL10 - tx-done sets at start of stop bit
// RL11 - receiver accepts frames only while rx enable is one
// RL12 - byte kept only if rx-done clear and multiproc check met
// RL13 - accepted byte stored, ninth bit stored, rx-done set
// RL14 - timer clock system_clock if select, else prescale 12/4/48
// RL15 - one bit lasts two overflows of 8-bit reload timer
// RL16 - 8-bit frame: start, 8 data lsb first, stop
module async_serial_port
   import serial_port_pkg::*;
(
   input  wire logic       clk,               // 125 MHz system clock
   input  wire logic       resetn,            // async reset, low
   input  wire logic       data_wr,           // write strobe to data window
   input  wire logic [7:0] data_wdata,        // byte to transmit
   input  wire logic       ctrl_wr,           // write strobe to control register
   input  wire logic [7:0] ctrl_wdata,        // control write value
   input  wire logic       irq_enable,        // port interrupt enable
   input  wire logic       baud_system_clock_sel,   // timer clock is system clock
   input  wire logic [1:0] baud_prescale_sel, // prescale select
   input  wire logic [7:0] baud_reload,       // timer reload value
   input  wire logic       rxd,               // serial input pin
   output logic      [7:0] data_rdata,        // receive buffer
   output logic      [7:0] ctrl_rdata,        // control register
   output logic            txd,               // serial output pin
   output logic            irq                // port interrupt
);
   typedef struct packed {
      logic [1:0] rx_sync;
      logic [5:0] presc_cnt;
      logic [7:0] timer;
      logic [3:0] tx_tick;
      logic [3:0] rx_tick;
      ser_state_t tx_st;
      logic [8:0] tx_shift;
      logic [3:0] tx_cnt;
      ser_state_t rx_st;
      logic [8:0] rx_shift;
      logic [3:0] rx_cnt;
      logic       mode9;
      logic       mce;
      logic       ren;
      logic       tb8;
      logic       rb8;
      logic       ti;
      logic       ri;
      logic       txd;
      logic       irq;
      logic [7:0] ctrl;
   } state_t;
   state_t s_reg, s_next;
   logic       buf_wr;
   logic [7:0] buf_data;
   logic       pre_en, ovf, tx_bit_en, rx_half_en;
   logic [5:0] div;

   // data window read side lives in a registered buffer, so rx can refill the shifter [RL2] [RL3]
   rx_holding_buffer u_buf (
      .clk     (clk),
      .resetn  (resetn),
      .wr_en   (buf_wr),
      .wr_data (buf_data),
      .rd_data (data_rdata)
   );

   function automatic logic [5:0] presc_div(input logic [1:0] sel);
      case (sel)
         PRESC_4:  presc_div = DIV_4;
         PRESC_48: presc_div = DIV_48;
         default:  presc_div = DIV_12;  // reserved code treated as /12
      endcase
   endfunction

   always_comb begin
      s_next = s_reg;
      buf_wr = 1'b0;
      buf_data = s_reg.rx_shift[7:0];
      s_next.rx_sync = {s_reg.rx_sync[0], rxd};
      div = presc_div(baud_prescale_sel);
      // timer clock enable [RL14]
      pre_en = 1'b0;
      if (baud_system_clock_sel) begin
         pre_en = 1'b1;
      end else if (s_reg.presc_cnt == div - 6'h01) begin
         pre_en = 1'b1;
         s_next.presc_cnt = 6'h00;
      end else begin
         s_next.presc_cnt = s_reg.presc_cnt + 6'h01;
      end
      // 8-bit auto-reload timer
      ovf = 1'b0;
      if (pre_en) begin
         if (s_reg.timer == 8'hFF) begin
            ovf = 1'b1;
            s_next.timer = baud_reload;
         end else begin
            s_next.timer = s_reg.timer + 8'h01;
         end
      end
      // tx bit = two overflows [RL15]
      tx_bit_en = 1'b0;
      if (ovf) begin
         if (s_reg.tx_tick == OVF_PER_BIT - 4'h1) begin
            tx_bit_en = 1'b1;
            s_next.tx_tick = 4'h0;
         end else begin
            s_next.tx_tick = s_reg.tx_tick + 4'h1;
         end
      end
      // rx samples at overflow rate: two ticks per bit, data sampled on the second tick of each pair (rx_tick odd)
      rx_half_en = ovf;
      // control writes; hardware sets win over clears [RL5]
      if (ctrl_wr) begin
         s_next.mode9 = ctrl_wdata[MODE_BIT];  // [RL1]
         s_next.mce   = ctrl_wdata[MCE_BIT];
         s_next.ren   = ctrl_wdata[REN_BIT];
         s_next.tb8   = ctrl_wdata[TB8_BIT];
         s_next.rb8   = ctrl_wdata[RB8_BIT];
         s_next.ti    = ctrl_wdata[TI_BIT];
         s_next.ri    = ctrl_wdata[RI_BIT];
      end
      // transmitter [RL1]
      case (s_reg.tx_st)
         S_IDLE: begin
            s_next.txd = 1'b1;
            if (data_wr) begin  // [RL9]
               s_next.tx_shift = {s_next.tb8, data_wdata};  // [RL7]
               s_next.tx_st = S_START;
               s_next.tx_tick = 4'h0;
            end
         end
         S_START: if (tx_bit_en) begin
            s_next.txd = 1'b0;
            s_next.tx_cnt = 4'h0;
            s_next.tx_st = S_DATA;
         end
         S_DATA: if (tx_bit_en) begin
            if (s_reg.tx_cnt == DATA_BITS + {3'h0, s_reg.mode9}) begin  // [RL6] [RL16]
               s_next.txd = 1'b1;
               s_next.ti = 1'b1;  // [RL10]
               s_next.tx_st = S_STOP;
            end else begin
               s_next.txd = s_reg.tx_shift[0];  // lsb first [RL6]
               s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
               s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
            end
         end
         S_STOP: if (tx_bit_en) begin
            s_next.tx_st = S_IDLE;
         end
         default: s_next.tx_st = S_IDLE;
      endcase
      // receiver
      case (s_reg.rx_st)
         S_IDLE: begin
            if (s_reg.ren && !s_reg.rx_sync[1]) begin  // [RL11]
               s_next.rx_st = S_START;
               s_next.rx_tick = 4'h0;
            end
         end
         S_START: if (rx_half_en) begin
            if (s_reg.rx_sync[1]) begin
               s_next.rx_st = S_IDLE;  // false start
            end else begin
               s_next.rx_st = S_DATA;
               s_next.rx_cnt = 4'h0;
               s_next.rx_tick = 4'h0;
            end
         end
         S_DATA: if (rx_half_en) begin
            s_next.rx_tick = s_reg.rx_tick + 4'h1;
            if (s_reg.rx_tick[0]) begin
               if (s_reg.rx_cnt == DATA_BITS + {3'h0, s_reg.mode9}) begin
                  s_next.rx_st = S_STOP;  // stop bit value ignored [RL8]
               end else begin
                  s_next.rx_shift = s_reg.mode9 ? {s_reg.rx_sync[1], s_reg.rx_shift[8:1]}
                                                : {1'b0, s_reg.rx_sync[1], s_reg.rx_shift[7:1]};
                  s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
               end
            end
         end
         S_STOP: begin
            s_next.rx_st = S_IDLE;
            if (!s_reg.ri && (!s_reg.mce || !s_reg.mode9 || s_reg.rx_shift[8])) begin  // [RL12]
               buf_wr = 1'b1;  // [RL13]
               s_next.ri = 1'b1;
               s_next.rb8 = s_reg.mode9 ? s_reg.rx_shift[8] : s_reg.rb8;  // [RL8]
            end
         end
         default: s_next.rx_st = S_IDLE;
      endcase
      s_next.irq = irq_enable && (s_next.ti || s_next.ri);  // [RL4]
      s_next.ctrl = {s_next.mode9, 1'b0, s_next.mce, s_next.ren,
                     s_next.tb8, s_next.rb8, s_next.ti, s_next.ri};
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '{rx_sync: 2'h3, txd: 1'b1, tx_st: S_IDLE, rx_st: S_IDLE, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign txd = s_reg.txd;
   assign irq = s_reg.irq;
   assign ctrl_rdata = s_reg.ctrl;

   property p_tx_start;
      @(posedge clk) disable iff (!resetn)
      (data_wr && s_reg.tx_st == S_IDLE) |=> s_reg.tx_st == S_START;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("write did not start transmit"); // [RL9]
   property p_ti_set;
      @(posedge clk) disable iff (!resetn)
      ($rose(s_reg.tx_st == S_STOP)) |-> (s_reg.ti && s_reg.txd);
   endproperty
   a_ti_set: assert property (p_ti_set) else $error("tx done not set at stop"); // [RL10]
   property p_ri_hold;
      @(posedge clk) disable iff (!resetn)
      (s_reg.ri && !ctrl_wr) |=> s_reg.ri;
   endproperty
   a_ri_hold: assert property (p_ri_hold) else $error("rx done cleared by hardware"); // [RL5]
   property p_no_rx_off;
      @(posedge clk) disable iff (!resetn)
      (s_reg.rx_st == S_IDLE && !s_reg.ren) |=> s_reg.rx_st == S_IDLE;
   endproperty
   a_no_rx_off: assert property (p_no_rx_off) else $error("rx started while disabled"); // [RL11]
   property p_accept;
      @(posedge clk) disable iff (!resetn)
      buf_wr |-> (!s_reg.ri ##1 s_reg.ri);
   endproperty
   a_accept: assert property (p_accept) else $error("accept without flag"); // [RL12]
   property p_rx_store;
      @(posedge clk) disable iff (!resetn)
      buf_wr |=> data_rdata == $past(buf_data);
   endproperty
   a_rx_store: assert property (p_rx_store) else $error("received byte not stored"); // [RL13]
   // irq is registered, so it follows the enable seen one edge earlier
   property p_irq;
      @(posedge clk) disable iff (!resetn)
      irq == ($past(irq_enable) && (s_reg.ti || s_reg.ri));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing"); // [RL4]
endmodule
`default_nettype wire

/* File: remote_station.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_station (
   input  wire logic clk, // system clock
   input  wire logic txd, // device serial out
   output logic      rxd  // device serial in
);
   int         bp = 16; // clocks per bit
   bit         m9 = 0;  // 9-bit frames
   int         rxq[$];  // captured frames, ninth in bit 8
   logic [8:0] v;
   initial rxd = 1'b1;
   // start, data lsb first, optional ninth, stop
   task automatic send(input logic [8:0] f);
      rxd <= 1'b0;
      repeat (bp) @(posedge clk);
      for (int i = 0; i < (m9 ? 9 : 8); i++) begin
         rxd <= f[i];
         repeat (bp) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (bp) @(posedge clk);
   endtask
   // sample mid-bit; a frame with a low stop is not kept
   always begin
      @(negedge txd);
      repeat (bp / 2) @(posedge clk);
      v = 9'h000;
      for (int i = 0; i < (m9 ? 9 : 8); i++) begin
         repeat (bp) @(posedge clk);
         v[i] = txd;
      end
      repeat (bp) @(posedge clk);
      if (txd === 1'b1) rxq.push_back(int'(v));
   end
endmodule
`default_nettype wire

/* File: rx_holding_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
// one-word holding register for the received byte
module rx_holding_buffer
   import serial_port_pkg::*;
(
   input  wire logic       clk,    // system clock
   input  wire logic       resetn, // async reset, low
   input  wire logic       wr_en,  // load strobe
   input  wire logic [7:0] wr_data,// byte in
   output logic      [7:0] rd_data // registered byte out
);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 8'h00;
      end else if (wr_en) begin
         rd_data <= wr_data;
      end
   end
endmodule
`default_nettype wire

/* File: serial_port_pkg.sv */
package serial_port_pkg;
   // control register bit positions
   localparam int RI_BIT   = 0;
   localparam int TI_BIT   = 1;
   localparam int RB8_BIT  = 2;
   localparam int TB8_BIT  = 3;
   localparam int REN_BIT  = 4;
   localparam int MCE_BIT  = 5;
   localparam int MODE_BIT = 7;
   localparam logic [1:0] PRESC_12 = 2'h0;
   localparam logic [1:0] PRESC_4  = 2'h1;
   localparam logic [1:0] PRESC_48 = 2'h2;
   localparam logic [5:0] DIV_12   = 6'h0C;
   localparam logic [5:0] DIV_4    = 6'h04;
   localparam logic [5:0] DIV_48   = 6'h30;
   localparam logic [3:0] OVF_PER_BIT  = 4'h2;
   localparam logic [3:0] RX_SAMPLES   = 4'h8;  // unused oversample count; the receiver takes two overflow ticks per bit
   localparam logic [3:0] DATA_BITS    = 4'h8;
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_START = 4'b0010,
      S_DATA  = 4'b0100,
      S_STOP  = 4'b1000
   } ser_state_t;
endpackage

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import serial_port_pkg::*;
   logic       clk, resetn, data_wr, ctrl_wr, irq_enable, sys_sel, txd, rxd, irq;
   logic       ri_m, rb8_m, ren_m, mce_m;
   logic [1:0] presc;
   logic [7:0] data_wdata, ctrl_wdata, reload, data_rdata, ctrl_rdata, dat_m, cv;
   int         errors = 0, cmp_count = 0, n, m;
   always #4 clk = ~clk;
   async_serial_port i_dut (.clk(clk), .resetn(resetn), .data_wr(data_wr), .data_wdata(data_wdata),
      .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .irq_enable(irq_enable), .baud_system_clock_sel(sys_sel),
      .baud_prescale_sel(presc), .baud_reload(reload), .rxd(rxd), .data_rdata(data_rdata),
      .ctrl_rdata(ctrl_rdata), .txd(txd), .irq(irq));
   remote_station i_remote (.clk(clk), .txd(txd), .rxd(rxd));
   task automatic chk(input logic [8:0] g, e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // software write also loads the ninth-bit view
   task automatic wctl(input logic [7:0] v);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= v;
      @(posedge clk);
      ctrl_wr <= 1'b0;
      {cv, ren_m, mce_m, rb8_m} = {v, v[REN_BIT], v[MCE_BIT], v[RB8_BIT]};
      ri_m = ri_m & v[RI_BIT];
      repeat (2) @(posedge clk);
      chk(ctrl_rdata[7:3], {v[7], 1'b0, v[5:3]});
   endtask
   task automatic txf(input logic m9, tb, input logic [7:0] d);
      wctl({m9, 3'b000, tb, 3'b000});
      i_remote.m9 = m9;
      data_wr <= 1'b1;
      data_wdata <= d;
      @(posedge clk);
      data_wr <= 1'b0;
      for (n = 0; n < 5000 && ctrl_rdata[TI_BIT] !== 1'b1; n++) @(posedge clk);
      @(posedge clk);
      chk(txd, 1'b1);
      chk(9'(i_remote.rxq.size()), 9'h000);
      chk(irq, 1'b1);
      repeat (i_remote.bp) @(posedge clk);
      chk(9'(i_remote.rxq.pop_front()), {m9 & tb, d});
      chk(ctrl_rdata[TI_BIT], 1'b1);
      wctl(8'h00);
      chk({irq, ctrl_rdata[TI_BIT]}, 9'h000);
   endtask
   // clr: software reads the buffer and clears rx-done while the next frame shifts in
   task automatic rx(input logic [8:0] v, input bit clr);
      fork
         i_remote.send(v);
         if (clr) begin
            repeat (i_remote.bp * 3) @(posedge clk);
            chk(data_rdata, dat_m);
            wctl(cv);
         end
      join
      repeat (6) @(posedge clk);
      if (ren_m && !ri_m && (!mce_m || !cv[MODE_BIT] || v[8]))
         {ri_m, rb8_m, dat_m} = {1'b1, cv[MODE_BIT] ? v[8] : rb8_m, v[7:0]};
      chk(ctrl_rdata[RI_BIT], ri_m);
      chk(data_rdata, dat_m);
      chk(ctrl_rdata[RB8_BIT], rb8_m);
      chk(irq, ri_m);
   endtask
   initial begin
      {clk, resetn, data_wr, ctrl_wr, irq_enable, sys_sel} = 6'b000011;
      {presc, data_wdata, ctrl_wdata, reload, cv} = {2'b00, 16'h0000, 8'hF8, 8'h00};
      {ri_m, rb8_m, ren_m, mce_m, dat_m} = '0;
      void'($urandom(77170));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 3; k++) txf(k > 0, k == 2, 8'($urandom));
      i_remote.m9 = 1;
      wctl(8'h80);
      rx({1'b1, 8'($urandom)}, 0);
      wctl(8'h90);
      rx({1'b0, 8'($urandom)}, 0);
      rx({1'b1, 8'($urandom)}, 0);
      rx({1'b1, 8'($urandom)}, 1);
      wctl(8'hB0);
      rx({1'b0, 8'($urandom)}, 0);
      rx({1'b1, 8'($urandom)}, 0);
      // 8-bit frames must leave the stored ninth bit alone
      i_remote.m9 = 0;
      wctl(8'h14);
      rx({1'b0, 8'($urandom)}, 0);
      // start bit length gives the bit period for each clock choice
      for (int k = 0; k < 4; k++) begin
         {sys_sel, presc, reload} <= {k == 3, 2'(k), 8'hFC};
         n = (k == 3) ? 8 : 8 * (k == 0 ? 12 : k == 1 ? 4 : 48);
         i_remote.bp = n;
         fork
            txf(0, 0, 8'hFF);
            begin
               @(negedge txd);
               @(negedge clk);
               for (m = 0; txd === 1'b0; m++) @(negedge clk);
            end
         join
         chk(9'(m), 9'(i_remote.bp));
      end
      test_done;
   end
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      test_done;
   end
endmodule
`default_nettype wire
